// ---- rtl/ccr_pkg.sv ----
// Shared constants and types for the CPU core register set
package ccr_pkg;

  // ************************************************************
  // Core register geometry
  // ************************************************************
  localparam int PC_W = 16;
  localparam int PROG_BYTES = 8192;
  localparam int PROG_ADDR_W = $clog2(PROG_BYTES);
  localparam int DATA_W = 8;

  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] X_RST = 8'h00;
  localparam logic [7:0] SP_RST = 8'h00;
  // Zero flag comes up set, everything else clear
  localparam logic [7:0] FLAGS_RST = 8'h02;

  localparam int FLAG_GIE = 0;
  localparam int FLAG_ZERO = 1;
  localparam int FLAG_CARRY = 2;
  localparam int FLAG_SUPER = 3;
  localparam int FLAG_XIO = 4;
  // Bits an instruction may write; supervisory bit and bits 7:5 excluded
  localparam logic [7:0] FLAGS_USER_MASK = 8'h17;
  localparam logic [7:0] FLAGS_SUPER_MASK = 8'h08;

  localparam logic [7:0] SP_STEP_PUSH = 8'h01;
  localparam logic [7:0] SP_STEP_CALL = 8'h02;
  localparam logic [7:0] SP_STEP_RET = 8'h02;
  localparam logic [7:0] SP_STEP_RETI = 8'h03;

  // ************************************************************
  // Bus register map
  // ************************************************************
  localparam int AXI_ADDR_W = 4;
  localparam logic [3:0] OFS_PIN_CTRL = 4'h0;
  localparam logic [3:0] OFS_PIN_STAT = 4'h4;
  localparam int CTRL_ALT_LSB = 0;
  localparam int CTRL_DIR_LSB = 2;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int STAT_LVL_LSB = 0;
  localparam int STAT_OE_LSB = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ************************************************************
  // Execution commands
  // ************************************************************
  typedef enum logic [3:0] {
    OP_NOP = 4'b0000, OP_MOV = 4'b0001, OP_ADD = 4'b0010, OP_AND = 4'b0011,
    OP_OR = 4'b0100, OP_XOR = 4'b0101, OP_SHL = 4'b0110, OP_SHR = 4'b0111,
    OP_PUSH = 4'b1000, OP_POP = 4'b1001, OP_CALL = 4'b1010, OP_LCALL = 4'b1011,
    OP_RET = 4'b1100, OP_RETI = 4'b1101, OP_SWAP = 4'b1110, OP_JMP = 4'b1111
  } ccr_op_t;

  typedef enum logic [1:0] {
    DST_A = 2'b00, DST_X = 2'b01, DST_SP = 2'b10, DST_F = 2'b11
  } ccr_dst_t;

endpackage

// ---- rtl/ccr_axil_slave.sv ----
// AXI4-Lite slave front end with single-word register strobes
`timescale 1ns/1ps
module ccr_axil_slave
  import ccr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_stb,
  output logic [AXI_ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);

  logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [AXI_ADDR_W-1:0] addr_q, addr_d;
  logic [31:0] data_q, data_d, rdata_q, rdata_d;
  logic [3:0] strb_q, strb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic aw_now, w_now;

  assign awready = !aw_have_q && !bvalid_q;
  assign wready = !w_have_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign aw_now = aw_have_q || (awvalid && awready);
  assign w_now = w_have_q || (wvalid && wready);
  assign wr_stb = aw_now && w_now && !bvalid_q;
  assign wr_addr = aw_have_q ? addr_q : awaddr;
  assign wr_data = w_have_q ? data_q : wdata;
  assign wr_strb = w_have_q ? strb_q : wstrb;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;

  always_comb begin
    aw_have_d = aw_now && !wr_stb;
    w_have_d = w_now && !wr_stb;
    addr_d = wr_addr;
    data_d = wr_data;
    strb_d = wr_strb;
    bvalid_d = bvalid_q && !bready;
    bresp_d = bresp_q;
    if (wr_stb) begin
      bvalid_d = 1'b1;
      bresp_d = wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    rvalid_d = rvalid_q && !rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rdata_d = rd_data;
      rresp_d = rd_err ? RESP_SLVERR : RESP_OKAY;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      addr_q <= '0;
      data_q <= 32'h0000_0000;
      strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      addr_q <= addr_d;
      data_q <= data_d;
      strb_q <= strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

endmodule // ccr_axil_slave

// ---- rtl/ccr_timer_pin.sv ----
// One timer pin: port function or timer capture input / timer output
`timescale 1ns/1ps
module ccr_timer_pin (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic alt_en,
  input wire logic out_mode,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire logic timer_out,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  output logic capture,
  output logic gpio_in
);

  logic pin_o_q, pin_o_d, pin_oe_q, pin_oe_d, cap_q, cap_d, gin_q, gin_d;

  always_comb begin
    pin_o_d = alt_en ? timer_out : gpio_out;
    pin_oe_d = alt_en ? out_mode : gpio_oe;
    // Capture sees the pin only when it is not being driven by the timer
    cap_d = alt_en && !out_mode && pin_i;
    gin_d = pin_i;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
      cap_q <= 1'b0;
      gin_q <= 1'b0;
    end else begin
      pin_o_q <= pin_o_d;
      pin_oe_q <= pin_oe_d;
      cap_q <= cap_d;
      gin_q <= gin_d;
    end
  end

  assign pin_o = pin_o_q;
  assign pin_oe = pin_oe_q;
  assign capture = cap_q;
  assign gpio_in = gin_q;

endmodule // ccr_timer_pin

// ---- rtl/ccr_core_regs.sv ----
// CPU core register set: program counter, accumulator, index, stack pointer, flags
`timescale 1ns/1ps
module ccr_core_regs
  import ccr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic exec_valid,
  input ccr_op_t exec_op,
  input ccr_dst_t exec_dst,
  input wire logic [7:0] exec_operand,
  input wire logic [15:0] exec_target,
  input wire logic [1:0] exec_len,
  input wire logic sup_enter,
  input wire logic sup_exit,
  input wire logic irq_req,
  output logic irq_take,
  input wire logic [7:0] idx_offset,
  output logic [7:0] idx_addr,
  output logic [15:0] program_counter,
  output logic [PROG_ADDR_W-1:0] prog_addr,
  output logic [7:0] accumulator,
  output logic [7:0] index_reg,
  output logic [7:0] stack_pointer_reg,
  output logic [7:0] processor_flags,
  input wire logic timer_pin_0_i,
  output logic timer_pin_0_o,
  output logic timer_pin_0_oe,
  input wire logic timer_pin_1_i,
  output logic timer_pin_1_o,
  output logic timer_pin_1_oe,
  input wire logic [1:0] gpio_out,
  input wire logic [1:0] gpio_oe,
  output logic [1:0] gpio_in,
  input wire logic [1:0] timer_out,
  output logic [1:0] timer_capture
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (PC_W < PROG_ADDR_W) begin : g_bad_pc
    $error("Program counter narrower than program address");
  end

  // ************************************************************
  // Bus slave and pin control register
  // ************************************************************
  logic wr_stb, wr_err, rd_err;
  logic [AXI_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [1:0] pin_lvl, pin_oe;

  ccr_axil_slave u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // Core registers deliberately have no address here
  assign wr_err = (wr_addr != OFS_PIN_CTRL) && (wr_addr != OFS_PIN_STAT);
  assign rd_err = (s_axi_araddr != OFS_PIN_CTRL) && (s_axi_araddr != OFS_PIN_STAT);

  always_comb begin
    rd_data = 32'h0000_0000;
    if (s_axi_araddr == OFS_PIN_CTRL) begin
      rd_data[CTRL_W-1:0] = ctrl_q;
    end else if (s_axi_araddr == OFS_PIN_STAT) begin
      rd_data[STAT_LVL_LSB +: 2] = pin_lvl;
      rd_data[STAT_OE_LSB +: 2] = pin_oe;
    end
  end

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_stb && (wr_addr == OFS_PIN_CTRL) && wr_strb[0]) begin
      ctrl_d = wr_data[CTRL_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ************************************************************
  // Timer pins
  // ************************************************************
  ccr_timer_pin u_pin0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .alt_en(ctrl_q[CTRL_ALT_LSB]),
    .out_mode(ctrl_q[CTRL_DIR_LSB]),
    .gpio_out(gpio_out[0]),
    .gpio_oe(gpio_oe[0]),
    .timer_out(timer_out[0]),
    .pin_i(timer_pin_0_i),
    .pin_o(timer_pin_0_o),
    .pin_oe(timer_pin_0_oe),
    .capture(timer_capture[0]),
    .gpio_in(pin_lvl[0])
  );

  ccr_timer_pin u_pin1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .alt_en(ctrl_q[CTRL_ALT_LSB+1]),
    .out_mode(ctrl_q[CTRL_DIR_LSB+1]),
    .gpio_out(gpio_out[1]),
    .gpio_oe(gpio_oe[1]),
    .timer_out(timer_out[1]),
    .pin_i(timer_pin_1_i),
    .pin_o(timer_pin_1_o),
    .pin_oe(timer_pin_1_oe),
    .capture(timer_capture[1]),
    .gpio_in(pin_lvl[1])
  );

  assign pin_oe = {timer_pin_1_oe, timer_pin_0_oe};
  assign gpio_in = pin_lvl;

  // ************************************************************
  // Core registers
  // ************************************************************
  logic [15:0] pc_q, pc_d;
  logic [7:0] acc_q, acc_d, x_q, x_d, sp_q, sp_d, flags_q, flags_d, idx_q, idx_d;
  logic [7:0] cur, res;
  logic [8:0] sum;
  logic res_wr, upd_z, upd_c, new_c;

  always_comb begin
    pc_d = pc_q;
    acc_d = acc_q;
    x_d = x_q;
    sp_d = sp_q;
    flags_d = flags_q;
    res = 8'h00;
    res_wr = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    new_c = 1'b0;
    sum = 9'h000;
    case (exec_dst)
      DST_A: cur = acc_q;
      DST_X: cur = x_q;
      DST_SP: cur = sp_q;
      default: cur = flags_q;
    endcase
    if (exec_valid) begin
      pc_d = pc_q + {14'h0000, exec_len};
      case (exec_op)
        OP_MOV: begin
          res = exec_operand;
          res_wr = 1'b1;
        end
        OP_ADD: begin
          sum = {1'b0, cur} + {1'b0, exec_operand};
          res = sum[7:0];
          res_wr = (exec_dst != DST_F);
          upd_z = (exec_dst == DST_A) || (exec_dst == DST_X);
          upd_c = upd_z;
          new_c = sum[8];
        end
        OP_AND, OP_OR, OP_XOR: begin
          if (exec_op == OP_AND) begin
            res = cur & exec_operand;
          end else if (exec_op == OP_OR) begin
            res = cur | exec_operand;
          end else begin
            res = cur ^ exec_operand;
          end
          res_wr = 1'b1;
          upd_z = (exec_dst != DST_F) && (exec_dst != DST_SP);
        end
        OP_SHL, OP_SHR: begin
          res = (exec_op == OP_SHL) ? {cur[6:0], 1'b0} : {1'b0, cur[7:1]};
          new_c = (exec_op == OP_SHL) ? cur[7] : cur[0];
          res_wr = (exec_dst != DST_F);
          upd_z = res_wr;
          upd_c = res_wr;
        end
        OP_PUSH: sp_d = sp_q + SP_STEP_PUSH;
        OP_POP: begin
          sp_d = sp_q - SP_STEP_PUSH;
          res = exec_operand;
          res_wr = (exec_dst != DST_SP);
        end
        OP_CALL, OP_LCALL: begin
          sp_d = sp_q + SP_STEP_CALL;
          pc_d = exec_target;
        end
        OP_RET: begin
          sp_d = sp_q - SP_STEP_RET;
          pc_d = exec_target;
        end
        OP_RETI: begin
          sp_d = sp_q - SP_STEP_RETI;
          pc_d = exec_target;
          res = exec_operand;
          res_wr = 1'b1;
        end
        OP_SWAP: begin
          // Accumulator trades places with X or SP; with the flags as target the accumulator only takes their value
          acc_d = cur;
          res = acc_q;
          res_wr = (exec_dst != DST_A) && (exec_dst != DST_F);
        end
        OP_JMP: pc_d = exec_target;
        default: ;
      endcase
      if (exec_op == OP_RETI) begin
        flags_d = (res & FLAGS_USER_MASK) | (flags_q & FLAGS_SUPER_MASK);
      end else if (res_wr) begin
        case (exec_dst)
          DST_A: acc_d = res;
          DST_X: x_d = res;
          DST_SP: sp_d = res;
          default: flags_d = (res & FLAGS_USER_MASK) | (flags_q & FLAGS_SUPER_MASK);
        endcase
      end
      if (upd_z) begin
        flags_d[FLAG_ZERO] = (res == 8'h00);
      end
      if (upd_c) begin
        flags_d[FLAG_CARRY] = new_c;
      end
    end
    // Mode switch belongs to the core alone; entry wins if both arrive together
    if (sup_enter) begin
      flags_d[FLAG_SUPER] = 1'b1;
    end else if (sup_exit) begin
      flags_d[FLAG_SUPER] = 1'b0;
    end
    idx_d = x_q + idx_offset;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= PC_RST;
      acc_q <= ACC_RST;
      x_q <= X_RST;
      sp_q <= SP_RST;
      flags_q <= FLAGS_RST;
      idx_q <= 8'h00;
    end else begin
      pc_q <= pc_d;
      acc_q <= acc_d;
      x_q <= x_d;
      sp_q <= sp_d;
      flags_q <= flags_d;
      idx_q <= idx_d;
    end
  end

  assign irq_take = irq_req && flags_q[FLAG_GIE];
  assign program_counter = pc_q;
  assign prog_addr = pc_q[PROG_ADDR_W-1:0];
  assign accumulator = acc_q;
  assign index_reg = x_q;
  assign stack_pointer_reg = sp_q;
  assign processor_flags = flags_q;
  assign idx_addr = idx_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pc_advance: assert property (exec_valid && exec_op == OP_NOP |=> pc_q == $past(pc_q) + {14'h0000, $past(exec_len)})
    else $error("PC did not advance by instruction length");
  a_acc_load: assert property (exec_valid && exec_op == OP_MOV && exec_dst == DST_A |=> acc_q == $past(exec_operand))
    else $error("Accumulator missed move result");
  a_idx_form: assert property (aresetn |=> idx_addr == 8'($past(x_q) + $past(idx_offset)))
    else $error("Indexed address wrong");
  a_sp_push: assert property (exec_valid && exec_op == OP_PUSH |=> sp_q == $past(sp_q) + SP_STEP_PUSH)
    else $error("Push did not bump stack pointer");
  a_sp_reti: assert property (exec_valid && exec_op == OP_RETI |=> sp_q == $past(sp_q) - SP_STEP_RETI)
    else $error("Interrupt return stack pointer wrong");
  a_sp_swap: assert property (exec_valid && exec_op == OP_SWAP && exec_dst == DST_SP
                              |=> sp_q == $past(acc_q) && acc_q == $past(sp_q))
    else $error("Swap with stack pointer wrong");
  a_zero_flag: assert property (exec_valid && exec_op == OP_ADD && exec_dst == DST_A
                                |=> flags_q[FLAG_ZERO] == (acc_q == 8'h00))
    else $error("Zero flag does not track add result");
  a_super_hold: assert property (!sup_enter && !sup_exit |=> $stable(flags_q[FLAG_SUPER]))
    else $error("Supervisory bit changed by instruction");
  a_gie_block: assert property (!flags_q[FLAG_GIE] |-> !irq_take)
    else $error("Interrupt taken while disabled");
  a_reset_clear: assert property ($rose(aresetn) |-> pc_q == PC_RST && sp_q == SP_RST && !flags_q[FLAG_GIE])
    else $error("Core registers not cleared by reset");
  a_pin_drive: assert property ((ctrl_q[CTRL_ALT_LSB] && ctrl_q[CTRL_DIR_LSB]) [*2] |-> timer_pin_0_oe)
    else $error("Timer output mode not driving pin");
  a_bus_isolate: assert property (!exec_valid && !sup_enter && !sup_exit |=> $stable(pc_q) && $stable(acc_q))
    else $error("Core register changed without execution");

  c_push: cover property (exec_valid && exec_op == OP_PUSH);
  c_irq: cover property (irq_take);
  c_reti: cover property (exec_valid && exec_op == OP_RETI ##1 sup_exit);
  c_bus_write: cover property (wr_stb && wr_addr == OFS_PIN_CTRL);

endmodule // ccr_core_regs

// ---- sim/test_ccr_core_regs.sv ----
// Self-checking bench for the CPU core register set
`timescale 1ns/1ps
module test_ccr_core_regs;
  import ccr_pkg::*;
  // ************************************************************
  // Signals and reference model state
  // ************************************************************
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, exec_len, gpio_out, gpio_oe, gpio_in, timer_out, timer_capture, ext;
  logic exec_valid, sup_enter, sup_exit, irq_req, irq_take;
  ccr_op_t exec_op;
  ccr_dst_t exec_dst;
  logic [7:0] exec_operand, idx_offset, idx_addr, accumulator, index_reg, stack_pointer_reg, processor_flags;
  logic [15:0] exec_target, program_counter, m_pc;
  logic [PROG_ADDR_W-1:0] prog_addr;
  logic timer_pin_0_o, timer_pin_0_oe, timer_pin_1_o, timer_pin_1_oe;
  // Resolved pin level: the far side only shows its own level while the block is not driving
  wire timer_pin_0_i = timer_pin_0_oe ? timer_pin_0_o : ext[0];
  wire timer_pin_1_i = timer_pin_1_oe ? timer_pin_1_o : ext[1];
  logic [7:0] m_a, m_x, m_sp, m_f, pidx;
  logic [31:0] seed = 32'h0000_0657;
  int fail_count, n_tests;
  logic [69:0] nq[$];
  logic [33:0] bq[$];

  ccr_core_regs u_ccr_core_regs (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .exec_valid, .exec_op, .exec_dst, .exec_operand, .exec_target,
    .exec_len, .sup_enter, .sup_exit, .irq_req, .irq_take, .idx_offset, .idx_addr, .program_counter,
    .prog_addr, .accumulator, .index_reg, .stack_pointer_reg, .processor_flags, .timer_pin_0_i,
    .timer_pin_0_o, .timer_pin_0_oe, .timer_pin_1_i, .timer_pin_1_o, .timer_pin_1_oe, .gpio_out,
    .gpio_oe, .gpio_in, .timer_out, .timer_capture);

  // ************************************************************
  // Tasks
  // ************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp_reg(input logic [69:0] got, input logic [69:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
    cmp_reg(70'(got), 70'(exp));
  endtask

  task automatic do_reset(input int n);
    aresetn <= 1'b0;
    exec_valid <= 1'b0;
    sup_enter <= 1'b0;
    sup_exit <= 1'b0;
    repeat (n) @(posedge aclk);
    aresetn <= 1'b1;
    m_pc = 16'h0000;
    m_a = 8'h00;
    m_x = 8'h00;
    m_sp = 8'h00;
    m_f = 8'h02;
    pidx = 8'h00;
  endtask

  // One random cycle: an instruction, an idle cycle, or a supervisory switch
  task automatic step();
    logic [31:0] r, q;
    logic [7:0] v, nv, o, nf, nsp;
    logic [8:0] s;
    logic [15:0] npc;
    logic [2:0] k;
    ccr_op_t op;
    ccr_dst_t d;
    r = rnd();
    q = rnd();
    k = q[20:18];
    op = ccr_op_t'(r[3:0]);
    d = ccr_dst_t'(r[5:4]);
    o = r[13:6];
    if (d == DST_F && !(op inside {OP_AND, OP_OR, OP_XOR})) d = DST_A;
    if (d == DST_SP && !(op inside {OP_MOV, OP_ADD, OP_SWAP})) d = DST_X;
    if (op == OP_SWAP && d == DST_A) d = DST_X;
    exec_op <= op;
    exec_dst <= d;
    exec_operand <= o;
    exec_target <= q[15:0];
    exec_len <= q[17:16];
    irq_req <= r[14];
    idx_offset <= r[22:15];
    exec_valid <= k > 3'h1;
    sup_enter <= k == 3'h0 && r[30];
    sup_exit <= k == 3'h0 && r[31];
    nq.push_back({m_pc, m_a, m_x, m_sp, m_f, r[14] & m_f[0], m_pc[12:0], pidx});
    pidx = m_x + r[22:15];
    v = d == DST_X ? m_x : d == DST_SP ? m_sp : d == DST_F ? m_f : m_a;
    nv = v;
    nf = m_f;
    nsp = m_sp;
    npc = m_pc + q[17:16];
    if (k == 3'h0) begin
      if (r[30]) m_f[3] = 1'b1;
      else if (r[31]) m_f[3] = 1'b0;
    end else if (k > 3'h1) begin
      case (op)
        OP_MOV: nv = o;
        OP_ADD: begin
          s = {1'b0, v} + o;
          nv = s[7:0];
          if (d != DST_SP) nf[2:1] = {s[8], s[7:0] == 8'h00};
        end
        OP_AND, OP_OR, OP_XOR: begin
          nv = op == OP_AND ? v & o : op == OP_OR ? v | o : v ^ o;
          nf[1] = nv == 8'h00;
          if (d == DST_F) nf = (nv & 8'h17) | (m_f & 8'h08);
        end
        OP_SHL: begin
          nv = v << 1;
          nf[2:1] = {v[7], nv == 8'h00};
        end
        OP_SHR: begin
          nv = v >> 1;
          nf[2:1] = {v[0], nv == 8'h00};
        end
        OP_PUSH: nsp = m_sp + 8'h01;
        OP_POP: begin
          nsp = m_sp - 8'h01;
          nv = o;
        end
        OP_CALL, OP_LCALL: begin
          nsp = m_sp + 8'h02;
          npc = q[15:0];
        end
        OP_RET: begin
          nsp = m_sp - 8'h02;
          npc = q[15:0];
        end
        OP_RETI: begin
          nsp = m_sp - 8'h03;
          npc = q[15:0];
          nf = (o & 8'h17) | (m_f & 8'h08);
        end
        OP_SWAP: begin
          nv = m_a;
          m_a = v;
        end
        OP_JMP: npc = q[15:0];
        default: ;
      endcase
      m_pc = npc;
      m_f = nf;
      if (d == DST_A) m_a = nv;
      if (d == DST_X) m_x = nv;
      m_sp = d == DST_SP ? nv : nsp;
    end
    @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] dat, input logic [3:0] st, input logic [1:0] e);
    logic ad = 1'b0;
    logic wd = 1'b0;
    bq.push_back({e, 32'h0000_0000});
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin @(posedge aclk); end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    // Let an edge pass so a following call never raises bready in the same step
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] dat, input logic [1:0] e);
    bq.push_back({e, dat});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin @(posedge aclk); end while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do begin @(posedge aclk); end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Expected byte: capture[1:0], oe1, oe0, wire1, wire0, port levels[1:0]
  task automatic pins(input logic [7:0] e);
    repeat (4) @(posedge aclk);
    cmp_reg(70'({timer_capture, timer_pin_1_oe, timer_pin_0_oe, timer_pin_1_i, timer_pin_0_i, gpio_in}), 70'(e));
  endtask

  // ************************************************************
  // Result watcher, clock, watchdog and main sequence
  // ************************************************************
  always @(negedge aclk) begin
    if (nq.size() > 0) cmp_reg({program_counter, accumulator, index_reg, stack_pointer_reg, processor_flags,
      irq_take, prog_addr, idx_addr}, nq.pop_front());
  end

  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0) cmp_bus({s_axi_bresp, 32'h0000_0000}, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready && bq.size() > 0) cmp_bus({s_axi_rresp, s_axi_rdata}, bq.pop_front());
  end

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // A full run needs under 2000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    final_report();
  end

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, irq_req} = '0;
    {exec_operand, idx_offset, exec_target, exec_len} = '0;
    exec_op = OP_NOP;
    exec_dst = DST_A;
    gpio_out = 2'b11;
    gpio_oe = 2'b01;
    timer_out = 2'b01;
    ext = 2'b10;
    do_reset(20);
    repeat (400) step();
    exec_valid <= 1'b0;
    sup_enter <= 1'b0;
    sup_exit <= 1'b0;
    axi_rd(OFS_PIN_CTRL, 32'h0000_0000, RESP_OKAY);
    axi_wr(OFS_PIN_CTRL, 32'hFFFF_FFF3, 4'hF, RESP_OKAY);
    pins(8'h8A);
    axi_rd(OFS_PIN_STAT, 32'h0000_0002, RESP_OKAY);
    axi_wr(OFS_PIN_CTRL, 32'h0000_000F, 4'hF, RESP_OKAY);
    pins(8'h35);
    axi_rd(OFS_PIN_STAT, 32'h0000_000D, RESP_OKAY);
    axi_wr(OFS_PIN_CTRL, 32'h0000_0000, 4'hE, RESP_OKAY);
    axi_wr(OFS_PIN_STAT, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    axi_rd(OFS_PIN_CTRL, 32'h0000_000F, RESP_OKAY);
    axi_wr(OFS_PIN_CTRL, 32'h0000_0000, 4'hF, RESP_OKAY);
    pins(8'h1F);
    // Core registers have no bus address: both spare words must refuse
    for (int i = 2; i < 4; i++) begin
      axi_wr(4'(i * 4), 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
      axi_rd(4'(i * 4), 32'h0000_0000, RESP_SLVERR);
    end
    // The indexed address has caught up with the index register during the idle gap
    pidx = m_x + idx_offset;
    repeat (100) step();
    do_reset(2);
    repeat (300) step();
    @(posedge aclk);
    final_report();
  end
endmodule // test_ccr_core_regs
